//--- hdl/sdct_ctrl.sv
// Host command sequencer that enforces memory command timing
//
// Function
// - Activates to different banks at least 7.5 ns (1KB) or 10 ns (2KB) apart.
// - At most four activates inside any 37.5 ns (1KB) or 50 ns (2KB) window.
// - Column commands at least two clocks apart.
// - After write with auto precharge, wait write recovery plus precharge before activate.
// - End of write burst to read at least 7.5 ns fast or 10 ns slow grade.
// - Internal read point to precharge at least 7.5 ns.
// - Self refresh exit to non-read command waits refresh cycle plus 10 ns.
// - Self refresh exit to read waits 200 clocks.
// - Precharge power-down exit to non-read command waits 2 clocks.
// - Fast active power-down exit to read waits 2 clocks.
// - Slow active power-down exit to read waits 6 minus additive latency clocks.
// - Clock enable high and low pulses last at least 3 clocks.
// - Termination change to power-down entry at least 3 clocks.
// - After power-down exit, 8 clocks before synchronous termination changes.
// - Clock runs tIS+tCK+tIH after clock enable falls.
// - Mode register bit 12 selects fast or slow active power-down exit.
// - Read to precharge at least additive latency plus half burst length.
// - Activate spacing never below two clocks.
// - Two clocks after a mode register set before any command.
`timescale 1ns/1ps
module sdct_ctrl
   import sdct_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic req_valid,
   output logic req_ready,
   input wire sdct_cmd_e req_cmd,
   input wire logic [1:0] req_ba,
   input wire logic [13:0] req_addr,
   input wire logic page_2k,
   input wire logic slow_grade,
   output logic mem_ck,
   output logic mem_ck_n,
   output logic mem_cke,
   output logic mem_cs_n,
   output logic mem_ras_n,
   output logic mem_cas_n,
   output logic mem_we_n,
   output logic [1:0] mem_ba,
   output logic [13:0] mem_a,
   output logic mem_odt,
   output logic pd_active,
   output logic sref_active,
   output logic dqs_pair_en,
   output logic slow_exit
);
   typedef enum logic [1:0] {ST_ACTV, ST_PD, ST_SR} sdct_st_e;

   sdct_pin_if pif ();
   sdct_st_e st_q;
   logic tick, issue, ok;
   logic [2:0] cl_q, al_q, wr_q;
   logic [3:0] open_q;
   logic [7:0] rrd_q, ccd_q, wtr_q, rdblk_q, nrd_q, mrd_q;
   logic [7:0] cke_q, odt_q, axpd_q, hold_q;
   logic [7:0] faw_q [4];
   logic [7:0] ras_q [4];
   logic [7:0] pre_q [4];
   logic [7:0] act_q [4];
   logic [7:0] wl, t_rrd, t_faw, t_wtr, rd2pre, wr2pre, t_dal, t_xards;
   logic any_ok, nrd_ok, bank_open, all_closed;
   logic is_act, is_rd, is_wr, is_pre, is_mrs, is_pdx, is_srx, is_ckl;
   logic ck_run_q;

   // Load-or-count for a countdown; a load keeps the longer of two waits
   function automatic logic [7:0] nxt(input logic [7:0] cur, input logic ld, input logic [7:0] val);
      logic [7:0] d;
      logic [7:0] v;
      d = (tick && cur != 8'h00) ? cur - 8'h01 : cur;
      v = val - 8'h01;
      return (ld && v > d) ? v : d;
   endfunction

   // ***********************************************
   // Pin driver
   // ***********************************************
   sdct_pin_drv u_pin (
      .clk(clk),
      .reset(reset),
      .pif(pif),
      .mem_ck(mem_ck),
      .mem_ck_n(mem_ck_n),
      .mem_cke(mem_cke),
      .mem_cs_n(mem_cs_n),
      .mem_ras_n(mem_ras_n),
      .mem_cas_n(mem_cas_n),
      .mem_we_n(mem_we_n),
      .mem_ba(mem_ba),
      .mem_a(mem_a),
      .mem_odt(mem_odt)
   );

   assign tick = pif.tick;
   assign pif.issue = issue;
   assign pif.cmd = req_cmd;
   assign pif.ba = req_ba;
   assign pif.a = req_addr;
   assign pif.ck_run = ck_run_q;

   // ***********************************************
   // Derived waits
   // ***********************************************
   // Write latency is read latency less one
   assign wl = 8'(al_q) + 8'(cl_q) - 8'h01;
   assign t_rrd = page_2k ? T_RRD_2K : T_RRD_1K;
   assign t_faw = page_2k ? T_FAW_2K : T_FAW_1K;
   assign t_wtr = wl + BL_HALF + (slow_grade ? T_WTR_SLOW : T_WTR_FAST);
   // Internal read point sits additive latency after the command
   assign rd2pre = 8'(al_q) + ((T_RTP > BL_HALF) ? T_RTP : BL_HALF);
   assign wr2pre = wl + BL_HALF + 8'(wr_q) + 8'h01;
   assign t_dal = wr2pre + T_RP;
   // A large additive latency must not give a zero wait
   assign t_xards = (8'(al_q) < T_XARDS_BASE - 8'h01) ? T_XARDS_BASE - 8'(al_q) : 8'h01;

   // ***********************************************
   // Admission
   // ***********************************************
   assign bank_open = open_q[req_ba];
   assign all_closed = (open_q == 4'h0);
   assign any_ok = (mrd_q == 8'h00);
   assign nrd_ok = any_ok && (nrd_q == 8'h00);

   always_comb begin
      ok = 1'b0;
      unique case (req_cmd)
         CMD_ACT: ok = (st_q == ST_ACTV) && nrd_ok && rrd_q == 8'h00 && faw_q[3] == 8'h00
                       && act_q[req_ba] == 8'h00 && !bank_open;
         CMD_RD: ok = (st_q == ST_ACTV) && any_ok && ccd_q == 8'h00 && wtr_q == 8'h00
                      && rdblk_q == 8'h00 && bank_open;
         CMD_WR, CMD_WRA: ok = (st_q == ST_ACTV) && nrd_ok && ccd_q == 8'h00 && bank_open;
         CMD_PRE: ok = (st_q == ST_ACTV) && nrd_ok && bank_open && pre_q[req_ba] == 8'h00
                       && ras_q[req_ba] == 8'h00;
         CMD_MRS: ok = (st_q == ST_ACTV) && nrd_ok && all_closed;
         CMD_PDE: ok = (st_q == ST_ACTV) && nrd_ok && cke_q == 8'h00 && odt_q == 8'h00;
         CMD_SRE: ok = (st_q == ST_ACTV) && nrd_ok && all_closed && cke_q == 8'h00
                       && odt_q == 8'h00;
         CMD_PDX: ok = (st_q == ST_PD) && cke_q == 8'h00;
         CMD_SRX: ok = (st_q == ST_SR) && cke_q == 8'h00;
         CMD_ODT: ok = (st_q == ST_ACTV) && any_ok && axpd_q == 8'h00;
         default: ok = 1'b0;
      endcase
   end

   // Commands only go out on the memory clock phase that owns the pins
   assign req_ready = tick && ok;
   assign issue = req_valid && req_ready;
   assign is_act = issue && req_cmd == CMD_ACT;
   assign is_rd = issue && req_cmd == CMD_RD;
   assign is_wr = issue && (req_cmd == CMD_WR || req_cmd == CMD_WRA);
   assign is_pre = issue && (req_cmd == CMD_PRE || req_cmd == CMD_WRA);
   assign is_mrs = issue && req_cmd == CMD_MRS;
   assign is_pdx = issue && req_cmd == CMD_PDX;
   assign is_srx = issue && req_cmd == CMD_SRX;
   assign is_ckl = issue && (req_cmd == CMD_PDE || req_cmd == CMD_SRE);

   // ***********************************************
   // Power state
   // ***********************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         st_q <= ST_ACTV;
      end else if (issue) begin
         unique case (req_cmd)
            CMD_PDE: st_q <= ST_PD;
            CMD_SRE: st_q <= ST_SR;
            CMD_PDX, CMD_SRX: st_q <= ST_ACTV;
            default: st_q <= st_q;
         endcase
      end
   end

   assign pd_active = (st_q == ST_PD);
   assign sref_active = (st_q == ST_SR);

   // Clock may stop in self refresh once the hold and pulse width are met
   always_ff @(posedge clk) begin
      if (reset) begin
         ck_run_q <= 1'b1;
      end else begin
         ck_run_q <= !(st_q == ST_SR && hold_q == 8'h00 && cke_q == 8'h00)
                     || (req_valid && req_cmd == CMD_SRX);
      end
   end

   // ***********************************************
   // Mode tracking
   // ***********************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         cl_q <= CL_RST;
         wr_q <= WR_RST;
         al_q <= AL_RST;
         slow_exit <= 1'b0;
         dqs_pair_en <= 1'b1;
      end else if (is_mrs) begin
         if (req_ba == BA_MR) begin
            cl_q <= req_addr[MR_CL_LSB +: 3];
            wr_q <= req_addr[MR_WR_LSB +: 3];
            slow_exit <= req_addr[MR_PDX_BIT];
         end
         if (req_ba == BA_EMR) begin
            al_q <= req_addr[EMR_AL_LSB +: 3];
            dqs_pair_en <= !req_addr[EMR_DQSN_BIT];
         end
      end
   end

   // ***********************************************
   // Device-wide counters
   // ***********************************************
   // Every figure is held as whole memory clocks, rounded up
   always_ff @(posedge clk) begin
      if (reset) begin
         rrd_q <= 8'h00;
         ccd_q <= 8'h00;
         wtr_q <= 8'h00;
         mrd_q <= 8'h00;
      end else begin
         rrd_q <= nxt(rrd_q, is_act, t_rrd);
         ccd_q <= nxt(ccd_q, is_rd || is_wr, T_CCD);
         wtr_q <= nxt(wtr_q, is_wr, t_wtr);
         mrd_q <= nxt(mrd_q, is_mrs, T_MRD);
      end
   end

   // Exit waits and pulse widths
   always_ff @(posedge clk) begin
      if (reset) begin
         nrd_q <= 8'h00;
         rdblk_q <= 8'h00;
         cke_q <= 8'h00;
         odt_q <= 8'h00;
         axpd_q <= 8'h00;
         hold_q <= 8'h00;
      end else begin
         nrd_q <= nxt(nrd_q, is_srx || is_pdx, is_srx ? T_XSNR : T_XP);
         rdblk_q <= nxt(rdblk_q, is_srx || (is_pdx && !all_closed),
                        is_srx ? T_XSRD : (slow_exit ? t_xards : T_XARD));
         cke_q <= nxt(cke_q, is_ckl || is_pdx || is_srx, T_CKE);
         odt_q <= nxt(odt_q, issue && req_cmd == CMD_ODT, T_ANPD);
         axpd_q <= nxt(axpd_q, is_pdx || is_srx, T_AXPD);
         hold_q <= nxt(hold_q, is_ckl, T_HOLD);
      end
   end

   // ***********************************************
   // Four-activate window and per-bank counters
   // ***********************************************
   // Slot 3 holds the wait left by the fourth most recent activate
   for (genvar i = 0; i < 4; i++) begin : g_slot
      always_ff @(posedge clk) begin
         if (reset) begin
            faw_q[i] <= 8'h00;
         end else if (is_act) begin
            faw_q[i] <= (i == 0) ? t_faw - 8'h01 : nxt(faw_q[(i == 0) ? 0 : i - 1], 1'b0, 8'h01);
         end else begin
            faw_q[i] <= nxt(faw_q[i], 1'b0, 8'h01);
         end
      end

      logic hit;
      assign hit = (req_ba == 2'(i));

      always_ff @(posedge clk) begin
         if (reset) begin
            open_q[i] <= 1'b0;
         end else if (hit && is_act) begin
            open_q[i] <= 1'b1;
         end else if (hit && is_pre) begin
            open_q[i] <= 1'b0;
         end
      end

      always_ff @(posedge clk) begin
         if (reset) begin
            ras_q[i] <= 8'h00;
            pre_q[i] <= 8'h00;
            act_q[i] <= 8'h00;
         end else begin
            ras_q[i] <= nxt(ras_q[i], hit && is_act, T_RAS);
            pre_q[i] <= nxt(pre_q[i], hit && (is_rd || is_wr), is_rd ? rd2pre : wr2pre);
            act_q[i] <= nxt(act_q[i], hit && is_pre, (req_cmd == CMD_WRA) ? t_dal : T_RP);
         end
      end
   end

   // ***********************************************
   // Checks
   // ***********************************************
   // Memory clocks elapsed since each watched event, saturating
   logic [7:0] ev;
   logic [7:0] since_q [8];
   assign ev = {is_ckl, is_pdx || is_srx, issue && req_cmd == CMD_ODT, is_srx,
                is_mrs, is_ckl || is_pdx || is_srx, is_rd || is_wr, is_act};

   for (genvar e = 0; e < 8; e++) begin : g_since
      always_ff @(posedge clk) begin
         if (reset) begin
            since_q[e] <= 8'hFF;
         end else if (ev[e]) begin
            since_q[e] <= 8'h00;
         end else if (tick && since_q[e] != 8'hFF) begin
            since_q[e] <= since_q[e] + 8'h01;
         end
      end
   end

   AST_RRD: assert property (@(posedge clk) disable iff (reset)
      is_act |-> since_q[0] >= t_rrd - 8'h01) else $error("activates too close");
   AST_CCD: assert property (@(posedge clk) disable iff (reset)
      (is_rd || is_wr) |-> since_q[1] >= T_CCD - 8'h01) else $error("column commands too close");
   AST_CKE: assert property (@(posedge clk) disable iff (reset)
      (is_ckl || is_pdx || is_srx) |-> since_q[2] >= T_CKE - 8'h01)
      else $error("clock enable pulse too short");
   AST_MRD: assert property (@(posedge clk) disable iff (reset)
      issue |-> since_q[3] >= T_MRD - 8'h01) else $error("command too soon after mode set");
   AST_XSRD: assert property (@(posedge clk) disable iff (reset)
      is_rd |-> since_q[4] >= T_XSRD - 8'h01) else $error("read too soon after self refresh exit");
   AST_ANPD: assert property (@(posedge clk) disable iff (reset)
      is_ckl |-> since_q[5] >= T_ANPD - 8'h01) else $error("power-down too soon after termination change");
   AST_AXPD: assert property (@(posedge clk) disable iff (reset)
      (issue && req_cmd == CMD_ODT) |-> since_q[6] >= T_AXPD - 8'h01)
      else $error("termination change too soon after exit");
   AST_HOLD: assert property (@(posedge clk) disable iff (reset)
      $fell(ck_run_q) |-> !mem_cke && since_q[7] >= T_HOLD - 8'h01) else $error("clock stopped too early");
   AST_PINS: assert property (@(posedge clk) disable iff (reset)
      is_act |=> (!mem_cs_n && !mem_ras_n && mem_cas_n) [*2]) else $error("activate not on pins");

   COV_ACT_RD: cover property (@(posedge clk) disable iff (reset) is_act ##[1:40] is_rd);
   COV_SREF: cover property (@(posedge clk) disable iff (reset) is_srx ##[1:500] is_rd);
   COV_PDX: cover property (@(posedge clk) disable iff (reset) is_pdx ##[1:20] is_rd);
endmodule // sdct_ctrl

//--- hdl/sdct_pin_drv.sv
// Pin driver: divides clk into the memory clock and registers command pins
`timescale 1ns/1ps
module sdct_pin_drv
   import sdct_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   sdct_pin_if.phy pif,
   output logic mem_ck,
   output logic mem_ck_n,
   output logic mem_cke,
   output logic mem_cs_n,
   output logic mem_ras_n,
   output logic mem_cas_n,
   output logic mem_we_n,
   output logic [1:0] mem_ba,
   output logic [13:0] mem_a,
   output logic mem_odt
);
   logic ck_q;
   logic ck_d;
   logic [3:0] pins_d;
   logic [13:0] a_d;

   // ***********************************************
   // Clock divider
   // ***********************************************
   // A stop only takes effect low, so no runt high phase reaches the part
   assign ck_d = (pif.ck_run || ck_q) ? ~ck_q : ck_q;
   assign pif.tick = ck_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         ck_q <= 1'b0;
         mem_ck <= 1'b0;
         mem_ck_n <= 1'b1;
      end else begin
         ck_q <= ck_d;
         mem_ck <= ck_d;
         mem_ck_n <= ~ck_d;
      end
   end

   // ***********************************************
   // Command pins
   // ***********************************************
   // Pins change at the falling memory clock, centred for the next rise
   always_comb begin
      pins_d = PIN_NOP;
      if (pif.issue) begin
         unique case (pif.cmd)
            CMD_ACT: pins_d = PIN_ACT;
            CMD_RD: pins_d = PIN_RD;
            CMD_WR, CMD_WRA: pins_d = PIN_WR;
            CMD_PRE: pins_d = PIN_PRE;
            CMD_MRS: pins_d = PIN_MRS;
            CMD_SRE: pins_d = PIN_REF;
            default: pins_d = PIN_NOP;
         endcase
      end
   end

   // Bit 10 is the auto precharge flag on column and precharge commands, so those set it and the caller cannot
   always_comb begin
      a_d = pif.a;
      if (pif.cmd == CMD_WRA) a_d[AP_BIT] = 1'b1;
      if (pif.cmd == CMD_RD || pif.cmd == CMD_WR || pif.cmd == CMD_PRE) a_d[AP_BIT] = 1'b0;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= PIN_NOP;
         mem_ba <= 2'h0;
         mem_a <= 14'h0000;
      end else if (pif.tick) begin
         {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= pins_d;
         mem_ba <= pif.ba;
         mem_a <= a_d;
      end
   end

   // Clock enable and termination levels follow their commands
   always_ff @(posedge clk) begin
      if (reset) begin
         mem_cke <= 1'b1;
         mem_odt <= 1'b0;
      end else if (pif.issue) begin
         if (pif.cmd == CMD_PDE || pif.cmd == CMD_SRE) mem_cke <= 1'b0;
         if (pif.cmd == CMD_PDX || pif.cmd == CMD_SRX) mem_cke <= 1'b1;
         if (pif.cmd == CMD_ODT) mem_odt <= pif.a[0];
      end
   end
endmodule // sdct_pin_drv

//--- hdl/sdct_pin_if.sv
// Interface: scheduled command from the sequencer to the pin driver
`timescale 1ns/1ps
interface sdct_pin_if;
   import sdct_pkg::*;
   logic tick;
   logic ck_run;
   logic issue;
   sdct_cmd_e cmd;
   logic [1:0] ba;
   logic [13:0] a;
   modport sched (input tick, output ck_run, output issue, output cmd, output ba, output a);
   modport phy (output tick, input ck_run, input issue, input cmd, input ba, input a);
endinterface // sdct_pin_if

//--- hdl/sdct_pkg.sv
// Package: command codes, pin encodings, field positions and timing counts
package sdct_pkg;

   // ***********************************************
   // Host commands
   // ***********************************************
   typedef enum logic [3:0] {
      CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_WRA, CMD_PRE, CMD_MRS,
      CMD_PDE, CMD_PDX, CMD_SRE, CMD_SRX, CMD_ODT
   } sdct_cmd_e;

   // ***********************************************
   // Clocking: memory clock is clk divided by two
   // ***********************************************
   localparam int CLK_PS = 25000;
   localparam int CK_DIV = 2;
   localparam int TCK_PS = CLK_PS * CK_DIV;

   // Round a least time up to whole memory clocks, never below minc
   function automatic int tck(input int ps, input int minc);
      int c;
      c = (ps + TCK_PS - 1) / TCK_PS;
      return (c < minc) ? minc : c;
   endfunction

   // ***********************************************
   // Times as printed
   // ***********************************************
   localparam int RRD_1K_PS = 7500;
   localparam int RRD_2K_PS = 10000;
   localparam int FAW_1K_PS = 37500;
   localparam int FAW_2K_PS = 50000;
   localparam int WTR_FAST_PS = 7500;
   localparam int WTR_SLOW_PS = 10000;
   localparam int RTP_PS = 7500;
   localparam int RP_PS = 15000;
   localparam int RAS_PS = 45000;
   localparam int RFC_PS = 75000;
   localparam int XSNR_EXTRA_PS = 10000;
   localparam int IS_PS = 350;
   localparam int IH_PS = 475;

   // ***********************************************
   // Counts in memory clocks
   // ***********************************************
   localparam logic [7:0] T_RRD_MIN = 8'h02;
   localparam logic [7:0] T_RRD_1K = 8'(tck(RRD_1K_PS, int'(T_RRD_MIN)));
   localparam logic [7:0] T_RRD_2K = 8'(tck(RRD_2K_PS, int'(T_RRD_MIN)));
   localparam logic [7:0] T_FAW_1K = 8'(tck(FAW_1K_PS, 1));
   localparam logic [7:0] T_FAW_2K = 8'(tck(FAW_2K_PS, 1));
   localparam logic [7:0] T_WTR_FAST = 8'(tck(WTR_FAST_PS, 1));
   localparam logic [7:0] T_WTR_SLOW = 8'(tck(WTR_SLOW_PS, 1));
   localparam logic [7:0] T_RTP = 8'(tck(RTP_PS, 1));
   localparam logic [7:0] T_RP = 8'(tck(RP_PS, 1));
   localparam logic [7:0] T_RAS = 8'(tck(RAS_PS, 1));
   localparam logic [7:0] T_XSNR = 8'(tck(RFC_PS + XSNR_EXTRA_PS, 1));
   localparam logic [7:0] T_HOLD = 8'(tck(IS_PS + TCK_PS + IH_PS, 1));
   localparam logic [7:0] T_CCD = 8'h02;
   localparam logic [7:0] T_XSRD = 8'hC8;
   localparam logic [7:0] T_XP = 8'h02;
   localparam logic [7:0] T_XARD = 8'h02;
   localparam logic [7:0] T_XARDS_BASE = 8'h06;
   localparam logic [7:0] T_CKE = 8'h03;
   localparam logic [7:0] T_ANPD = 8'h03;
   localparam logic [7:0] T_AXPD = 8'h08;
   localparam logic [7:0] T_MRD = 8'h02;
   localparam logic [7:0] BL_HALF = 8'h02;

   // ***********************************************
   // Mode register fields and reset values
   // ***********************************************
   localparam int MR_CL_LSB = 4;
   localparam int MR_WR_LSB = 9;
   localparam int MR_PDX_BIT = 12;
   localparam int EMR_AL_LSB = 3;
   localparam int EMR_DQSN_BIT = 10;
   localparam int AP_BIT = 10;
   localparam logic [1:0] BA_MR = 2'h0;
   localparam logic [1:0] BA_EMR = 2'h1;
   localparam logic [2:0] CL_RST = 3'h3;
   localparam logic [2:0] AL_RST = 3'h0;
   localparam logic [2:0] WR_RST = 3'h2;

   // ***********************************************
   // Pin encodings {cs_n, ras_n, cas_n, we_n}
   // ***********************************************
   localparam logic [3:0] PIN_NOP = 4'h7;
   localparam logic [3:0] PIN_ACT = 4'h3;
   localparam logic [3:0] PIN_RD = 4'h5;
   localparam logic [3:0] PIN_WR = 4'h4;
   localparam logic [3:0] PIN_PRE = 4'h2;
   localparam logic [3:0] PIN_MRS = 4'h0;
   localparam logic [3:0] PIN_REF = 4'h1;

endpackage

//--- verif/sdct_dev_model.sv
// Device model: takes commands on the memory clock and times them
`timescale 1ns/1ps
module sdct_dev_model
   import sdct_pkg::*;
(
   input wire logic ck,
   input wire logic cke,
   input wire logic [3:0] pins,
   input wire logic [1:0] ba,
   input wire logic [13:0] a,
   input wire logic odt,
   output logic [15:0] gap,
   output logic [15:0] since_exit,
   output logic [15:0] low_len,
   output logic [15:0] odt_gap,
   output logic [15:0] odt_exit,
   output logic strobe_single,
   output logic slow_mode
);
   logic [15:0] cnt = 16'h0;
   logic [15:0] last_cnt, exit_cnt, fall_cnt, odt_cnt;
   logic cke_q = 1'b1;
   logic odt_q = 1'b0;
   // Stamps in memory clocks; a stopped clock freezes them all
   always @(posedge ck) begin
      cnt <= cnt + 16'h1;
      cke_q <= cke;
      odt_q <= odt;
      if (odt !== odt_q) begin
         odt_cnt <= cnt;
         odt_exit <= cnt - exit_cnt;
      end
      if (cke && !cke_q) begin
         exit_cnt <= cnt;
         last_cnt <= cnt;
         low_len <= cnt - fall_cnt;
      end
      if (!cke && cke_q) begin
         fall_cnt <= cnt;
         odt_gap <= cnt - odt_cnt;
      end
      // Commands count only with clock enable high
      if (cke && pins != PIN_NOP) begin
         gap <= cnt - last_cnt;
         since_exit <= cnt - exit_cnt;
         last_cnt <= cnt;
         if (pins == PIN_MRS && ba == BA_EMR) strobe_single <= a[EMR_DQSN_BIT];
         if (pins == PIN_MRS && ba == BA_MR) slow_mode <= a[MR_PDX_BIT];
      end
   end
endmodule // sdct_dev_model

//--- verif/tb_top.sv
// Testbench: host requests in, command spacing judged at the memory pins
`timescale 1ns/1ps
module tb_top;
   import sdct_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic req_valid = 1'b0;
   sdct_cmd_e req_cmd = CMD_NOP;
   logic [1:0] req_ba = 2'h0;
   logic [13:0] req_addr = 14'h0;
   logic req_ready, mem_ck, cke, cs_n, ras_n, cas_n, we_n, odt, pd_active, sref_active, dqs_pair_en, slow_exit;
   logic ck_n;
   logic page_2k = 1'b0;
   logic slow_grade = 1'b0;
   logic [1:0] ba;
   logic [13:0] a;
   logic [15:0] gap, since_exit, low_len, odt_gap, odt_exit;
   logic strobe_single, slow_mode;
   int failures = 0;
   int tests_run = 0;
   // Clock at 40 MHz
   always #12.5 clk = ~clk;
   sdct_ctrl DUT (.clk(clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
      .req_ba(req_ba), .req_addr(req_addr), .page_2k(page_2k), .slow_grade(slow_grade),
      .mem_ck(mem_ck), .mem_ck_n(ck_n),
      .mem_cke(cke), .mem_cs_n(cs_n), .mem_ras_n(ras_n), .mem_cas_n(cas_n), .mem_we_n(we_n), .mem_ba(ba),
      .mem_a(a), .mem_odt(odt), .pd_active(pd_active), .sref_active(sref_active), .dqs_pair_en(dqs_pair_en),
      .slow_exit(slow_exit));
   sdct_dev_model MEM (.ck(mem_ck), .cke(cke), .pins({cs_n, ras_n, cas_n, we_n}), .ba(ba), .a(a), .odt(odt),
      .gap(gap), .since_exit(since_exit), .low_len(low_len), .odt_gap(odt_gap), .odt_exit(odt_exit),
      .strobe_single(strobe_single), .slow_mode(slow_mode));
   // Verdict and end of run
   task automatic finish_test();
      if (failures == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Hold a request until taken; with hold the next request follows at once, so gaps are the minimum
   task automatic send(input sdct_cmd_e c, input logic [1:0] b, input logic hold, input logic [13:0] v = 14'h0);
      int i;
      req_cmd = c;
      req_ba = b;
      req_addr = v;
      req_valid = 1'b1;
      i = 0;
      do begin
         @(negedge clk);
         i++;
      end while (req_ready !== 1'b1 && i < 2000);
      if (req_ready !== 1'b1) begin
         failures++;
         finish_test();
      end
      @(posedge clk);
      #1;
      if (!hold) begin
         req_valid = 1'b0;
         repeat (4) @(posedge clk);
         #1;
      end
   endtask
   task automatic t_mode();
      send(CMD_MRS, BA_MR, 1'b1, 14'h1432);
      send(CMD_MRS, BA_EMR, 1'b0, 14'h0400);
      check(gap, 16'(T_MRD));
      check(16'(slow_exit), 16'h1);
      check(16'(slow_mode), 16'h1);
      check(16'(dqs_pair_en), 16'h0);
      check(16'(strobe_single), 16'h1);
   endtask
   task automatic t_bank();
      send(CMD_ACT, 2'h0, 1'b1);
      send(CMD_ACT, 2'h1, 1'b0);
      check(gap, 16'(page_2k ? T_RRD_2K : T_RRD_1K));
      send(CMD_WR, 2'h0, 1'b1);
      send(CMD_RD, 2'h0, 1'b0);
      check(gap, 16'(CL_RST) + 16'h1 + 16'(slow_grade ? T_WTR_SLOW : T_WTR_FAST));
      send(CMD_RD, 2'h0, 1'b1);
      send(CMD_RD, 2'h1, 1'b0);
      check(gap, 16'(T_CCD));
      send(CMD_RD, 2'h1, 1'b1);
      send(CMD_PRE, 2'h1, 1'b0);
      check(gap, 16'(AL_RST) + 16'(BL_HALF));
      send(CMD_PRE, 2'h0, 1'b0);
      send(CMD_ACT, 2'h3, 1'b0);
      send(CMD_WRA, 2'h3, 1'b1);
      send(CMD_ACT, 2'h3, 1'b0);
      check(gap, 16'(CL_RST) + 16'(WR_RST) + 16'(T_RP) + 16'h2);
      send(CMD_PRE, 2'h3, 1'b0);
   endtask
   // Power-down: termination spacing, then precharge and slow active exits
   task automatic t_pd();
      send(CMD_ODT, 2'h0, 1'b1, 14'h1);
      send(CMD_PDE, 2'h0, 1'b0);
      check(16'(odt_gap >= 16'(T_ANPD)), 16'h1);
      send(CMD_PDX, 2'h0, 1'b1);
      send(CMD_ODT, 2'h0, 1'b0);
      check(16'(odt_exit >= 16'(T_AXPD)), 16'h1);
      check(16'(low_len >= 16'(T_CKE)), 16'h1);
      send(CMD_PDE, 2'h0, 1'b0);
      send(CMD_PDX, 2'h0, 1'b1);
      send(CMD_ACT, 2'h2, 1'b0);
      check(since_exit, 16'(T_XP));
      check(16'(pd_active), 16'h0);
      send(CMD_PDE, 2'h0, 1'b0);
      send(CMD_PDX, 2'h0, 1'b1);
      send(CMD_RD, 2'h2, 1'b0);
      check(since_exit, 16'(T_XARDS_BASE) - 16'(AL_RST));
      send(CMD_PRE, 2'h2, 1'b0);
   endtask
   // Self refresh: the memory clock must stop, then both exit waits
   task automatic t_sref();
      send(CMD_SRE, 2'h0, 1'b0);
      repeat (20) @(posedge clk);
      #1;
      check(16'(sref_active), 16'h1);
      check(16'(mem_ck), 16'h0);
      check(16'(ck_n), 16'h1);
      send(CMD_SRX, 2'h0, 1'b1);
      send(CMD_ACT, 2'h0, 1'b0);
      check(since_exit, 16'(T_XSNR));
      check(16'(low_len >= 16'(T_HOLD)), 16'h1);
      send(CMD_RD, 2'h0, 1'b0);
      check(since_exit, 16'(T_XSRD));
      send(CMD_PRE, 2'h0, 1'b0);
   endtask
   // Fast active power-down exit: reads may follow after the short wait
   task automatic t_fast();
      send(CMD_MRS, BA_MR, 1'b0, 14'h0432);
      check(16'(slow_exit), 16'h0);
      check(16'(slow_mode), 16'h0);
      send(CMD_ACT, 2'h1, 1'b0);
      send(CMD_PDE, 2'h0, 1'b0);
      send(CMD_PDX, 2'h0, 1'b1);
      send(CMD_RD, 2'h1, 1'b0);
      check(since_exit, 16'(T_XARD));
      send(CMD_PRE, 2'h1, 1'b0);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      #1;
      reset = 1'b0;
      t_mode();
      t_bank();
      t_pd();
      t_sref();
      t_fast();
      // Larger pages and the slower grade select the other timing set
      page_2k = 1'b1;
      slow_grade = 1'b1;
      t_bank();
      finish_test();
   end
endmodule // tb_top
